// *** adcs_pkg.sv ***
package adcs_pkg;

  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [7:0] ADCS_OFF_SC1    = 8'h00;
  localparam logic [7:0] ADCS_OFF_SC2    = 8'h04;
  localparam logic [7:0] ADCS_OFF_RESULT = 8'h08;
  localparam logic [7:0] ADCS_OFF_CMPVAL = 8'h0c;
  localparam logic [7:0] ADCS_OFF_CFG    = 8'h10;
  localparam logic [7:0] ADCS_OFF_PINEN0 = 8'h14;
  localparam logic [7:0] ADCS_OFF_PINEN1 = 8'h18;
  localparam logic [7:0] ADCS_OFF_PINEN2 = 8'h1c;

  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int SC1_FLAG_BIT  = 7;
  localparam int SC1_IRQEN_BIT = 6;
  localparam int SC1_CONT_BIT  = 5;
  localparam int SC2_BUSY_BIT  = 7;
  localparam int SC2_HWTRG_BIT = 6;
  localparam int SC2_CMPEN_BIT = 5;
  localparam int SC2_CMPGE_BIT = 4;
  localparam int CFG_LONG_BIT  = 3;
  localparam int CFG_MODE8_BIT = 2;

  // -----------------------------------------------------------------
  // Reset values and codes
  // -----------------------------------------------------------------
  localparam logic [4:0] CH_OFF        = 5'h1f;
  localparam logic [4:0] CH_PIN_LAST   = 5'h03;
  localparam logic [4:0] CH_GND_LAST   = 5'h15;
  localparam logic [4:0] CH_TEMP       = 5'h1a;
  localparam logic [4:0] CH_BANDGAP    = 5'h1b;
  localparam logic [4:0] CH_VREFL      = 5'h1e;
  localparam logic [4:0] CH_VREFH_LO   = 5'h1c;
  localparam logic [1:0] CLK_BUS       = 2'h0;
  localparam logic [1:0] CLK_BUS_DIV2  = 2'h1;
  localparam logic [1:0] CLK_ALT       = 2'h2;
  localparam logic [1:0] CLK_ASYNC     = 2'h3;
  localparam logic [1:0] MODE_RUN      = 2'h0;
  localparam logic [1:0] MODE_WAIT     = 2'h1;
  localparam logic [1:0] MODE_STOP3    = 2'h2;

  // -----------------------------------------------------------------
  // Timing counts, in conversion clock ticks
  // -----------------------------------------------------------------
  localparam int SAMPLE_SHORT_TICKS = 4;
  localparam int SAMPLE_LONG_TICKS  = 20;

  typedef enum logic [2:0] {
    ADCS_IDLE    = 3'b001,
    ADCS_SAMPLE  = 3'b010,
    ADCS_CONVERT = 3'b100
  } adcs_state_t;

endpackage : adcs_pkg

// *** adcs_sar.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcs_sar
  import adcs_pkg::*;
#(
  parameter int BITS = 10
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            start,
  input  wire logic            abort,
  input  wire logic            tick,
  input  wire logic            long_sample,
  input  wire logic            comp_in,
  output logic                 busy,
  output logic                 sampling,
  output logic                 done,
  output logic [BITS-1:0]      dac_code,
  output logic [BITS-1:0]      result
);

  initial begin
    if (BITS < 2 || BITS > 16) $error("adcs_sar: BITS out of range");
  end

  adcs_state_t     state_reg, state_next;
  logic [BITS-1:0] code_reg, code_next;
  logic [BITS-1:0] mask_reg, mask_next;
  logic [BITS-1:0] res_reg, res_next;
  logic [4:0]      cnt_reg, cnt_next;
  logic            done_reg, done_next;

  // -----------------------------------------------------------------
  // Sample then resolve one bit per tick, MSB first.
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    mask_next  = mask_reg;
    res_next   = res_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    if (start) begin
      state_next = ADCS_SAMPLE;
      cnt_next   = long_sample ? 5'(SAMPLE_LONG_TICKS - 1) : 5'(SAMPLE_SHORT_TICKS - 1);
      code_next  = '0;
      mask_next  = '0;
    end else if (abort) begin
      state_next = ADCS_IDLE;
      code_next  = '0;
      mask_next  = '0;
    end else begin
      case (state_reg)
        ADCS_IDLE: begin
        end
        ADCS_SAMPLE: begin
          if (tick) begin
            if (cnt_reg == 5'h00) begin
              state_next = ADCS_CONVERT;
              mask_next  = {1'b1, {(BITS-1){1'b0}}};
              code_next  = {1'b1, {(BITS-1){1'b0}}};
            end else begin
              cnt_next = cnt_reg - 5'h01;
            end
          end
        end
        ADCS_CONVERT: begin
          if (tick) begin
            code_next = (comp_in ? code_reg : (code_reg & ~mask_reg)) | (mask_reg >> 1);
            mask_next = mask_reg >> 1;
            if (mask_reg[0]) begin
              res_next   = comp_in ? code_reg : (code_reg & ~mask_reg);
              done_next  = 1'b1;
              state_next = ADCS_IDLE;
              code_next  = '0;
            end
          end
        end
        default: state_next = ADCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADCS_IDLE;
      code_reg  <= '0;
      mask_reg  <= '0;
      res_reg   <= '0;
      cnt_reg   <= 5'h00;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg  <= code_next;
      mask_reg  <= mask_next;
      res_reg   <= res_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
    end
  end

  assign busy     = (state_reg != ADCS_IDLE);
  assign sampling = (state_reg == ADCS_SAMPLE);
  assign done     = done_reg;
  assign dac_code = code_reg;
  assign result   = res_reg;

endmodule : adcs_sar
`default_nettype wire

// *** adcs_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcs_top
  import adcs_pkg::*;
#(
  parameter int BITS = 10
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            hw_conv_trigger,
  input  wire logic            async_conv_clock,
  input  wire logic [1:0]      sys_mode,
  input  wire logic            comp_in,
  output logic [BITS-1:0]      dac_code,
  output logic                 sample_hold,
  output logic [3:0]           mux_pin_sel,
  output logic                 mux_ground,
  output logic                 mux_temp,
  output logic                 mux_bandgap,
  output logic                 mux_vref_hi,
  output logic                 mux_vref_lo,
  output logic                 conv_irq
);

  initial begin
    if (BITS != 10) $error("adcs_top: result fields are laid out for 10 bits");
  end

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  logic [4:0]      channel_select_reg, channel_select_next;
  logic            conv_irq_enable_reg, conv_irq_enable_next;
  logic            continuous_conv_enable_reg, continuous_conv_enable_next;
  logic            conv_complete_flag_reg, conv_complete_flag_next;
  logic            hwtrg_sel_reg, hwtrg_sel_next;
  logic            compare_function_enable_reg, compare_function_enable_next;
  logic            cmp_ge_reg, cmp_ge_next;
  logic [BITS-1:0] cmp_val_reg, cmp_val_next;
  logic [1:0]      clk_sel_reg, clk_sel_next;
  logic            mode8_reg, mode8_next;
  logic            long_reg, long_next;
  logic [7:0]      analog_pin_enable_0_reg, analog_pin_enable_0_next;
  logic [BITS-1:0] result_reg, result_next;
  logic [31:0]     prdata_reg, prdata_next;
  logic            pready_reg, pready_next;
  logic            pslverr_reg, pslverr_next;
  logic            div2_reg, div2_next;
  logic            irq_reg, irq_next;
  logic [3:0]      pin_sel_reg, pin_sel_next;
  logic [4:0]      mux_reg, mux_next;

  logic            acc, wr, rd, sc1_wr, res_rd, mapped;
  logic            tick, start, abort, busy, sampling, done, trig_ok, cmp_true;
  logic [BITS-1:0] sar_result, sar_dac;
  logic [31:0]     rdata;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [BITS-1:0] adcs_fmt(input logic [BITS-1:0] v, input logic m8);
    adcs_fmt = m8 ? {2'b00, v[BITS-1:2]} : v;
  endfunction : adcs_fmt

  // Returns {ground, temp, bandgap, vref_hi, vref_lo}.
  function automatic logic [4:0] adcs_route(input logic [4:0] ch);
    adcs_route = 5'h00;
    if (ch > CH_PIN_LAST && ch <= CH_GND_LAST) adcs_route = 5'h10;
    else if (ch == CH_TEMP)                     adcs_route = 5'h08;
    else if (ch == CH_BANDGAP)                  adcs_route = 5'h04;
    else if (ch == CH_VREFL)                    adcs_route = 5'h01;
    else if (ch >= CH_VREFH_LO && ch < CH_VREFL) adcs_route = 5'h02;
  endfunction : adcs_route

  // -----------------------------------------------------------------
  // APB decode; the access phase always takes two cycles.
  // -----------------------------------------------------------------
  assign acc    = psel && penable && pready_reg;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign sc1_wr = wr && (paddr == ADCS_OFF_SC1);
  assign res_rd = rd && (paddr == ADCS_OFF_RESULT);
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADCS_OFF_PINEN2);

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      ADCS_OFF_SC1:    rdata[7:0] = {conv_complete_flag_reg, conv_irq_enable_reg,
                                     continuous_conv_enable_reg, channel_select_reg};
      ADCS_OFF_SC2:    rdata[7:4] = {busy, hwtrg_sel_reg, compare_function_enable_reg,
                                     cmp_ge_reg};
      ADCS_OFF_RESULT: rdata[BITS-1:0] = result_reg;
      ADCS_OFF_CMPVAL: rdata[BITS-1:0] = cmp_val_reg;
      ADCS_OFF_CFG:    rdata[3:0] = {long_reg, mode8_reg, clk_sel_reg};
      ADCS_OFF_PINEN0: rdata[7:0] = analog_pin_enable_0_reg;
      default:         rdata = 32'h0000_0000;
    endcase
  end

  // -----------------------------------------------------------------
  // Conversion clock select
  // -----------------------------------------------------------------
  always_comb begin
    div2_next = ~div2_reg;
    case (clk_sel_reg)
      CLK_BUS:      tick = 1'b1;
      CLK_BUS_DIV2: tick = div2_reg;
      CLK_ALT:      tick = 1'b0;
      CLK_ASYNC:    tick = async_conv_clock;
      default:      tick = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Start, abort and compare
  // -----------------------------------------------------------------
  // A control write in the same cycle wins over a trigger or a continuous restart.
  assign trig_ok = hw_conv_trigger && hwtrg_sel_reg && !busy && !sc1_wr &&
                   (channel_select_reg != CH_OFF) &&
                   (sys_mode == MODE_RUN || sys_mode == MODE_WAIT ||
                    sys_mode == MODE_STOP3);
  assign start = (sc1_wr && !hwtrg_sel_reg && pwdata[4:0] != CH_OFF) ||
                 trig_ok ||
                 (done && continuous_conv_enable_reg && !hwtrg_sel_reg && !sc1_wr &&
                  channel_select_reg != CH_OFF);
  // A write that selects the off code stops everything, including continuous mode.
  assign abort = sc1_wr;

  always_comb begin
    if (cmp_ge_reg) cmp_true = adcs_fmt(sar_result, mode8_reg) >= cmp_val_reg;
    else            cmp_true = adcs_fmt(sar_result, mode8_reg) < cmp_val_reg;
  end

  // -----------------------------------------------------------------
  // Register next state
  // -----------------------------------------------------------------
  always_comb begin
    channel_select_next          = channel_select_reg;
    conv_irq_enable_next         = conv_irq_enable_reg;
    continuous_conv_enable_next  = continuous_conv_enable_reg;
    hwtrg_sel_next               = hwtrg_sel_reg;
    compare_function_enable_next = compare_function_enable_reg;
    cmp_ge_next                  = cmp_ge_reg;
    cmp_val_next                 = cmp_val_reg;
    clk_sel_next                 = clk_sel_reg;
    mode8_next                   = mode8_reg;
    long_next                    = long_reg;
    analog_pin_enable_0_next     = analog_pin_enable_0_reg;
    result_next                  = result_reg;
    conv_complete_flag_next      = conv_complete_flag_reg;
    if (wr) begin
      case (paddr)
        ADCS_OFF_SC1: begin
          conv_irq_enable_next        = pwdata[SC1_IRQEN_BIT];
          continuous_conv_enable_next = pwdata[SC1_CONT_BIT];
          channel_select_next         = pwdata[4:0];
        end
        ADCS_OFF_SC2: begin
          hwtrg_sel_next               = pwdata[SC2_HWTRG_BIT];
          compare_function_enable_next = pwdata[SC2_CMPEN_BIT];
          cmp_ge_next                  = pwdata[SC2_CMPGE_BIT];
        end
        ADCS_OFF_CMPVAL: cmp_val_next = pwdata[BITS-1:0];
        ADCS_OFF_CFG: begin
          long_next    = pwdata[CFG_LONG_BIT];
          mode8_next   = pwdata[CFG_MODE8_BIT];
          clk_sel_next = pwdata[1:0];
        end
        ADCS_OFF_PINEN0: analog_pin_enable_0_next = pwdata[7:0];
        default: begin
        end
      endcase
    end
    if (sc1_wr || res_rd) conv_complete_flag_next = 1'b0;
    if (done) begin
      result_next = adcs_fmt(sar_result, mode8_reg);
      if (!compare_function_enable_reg || cmp_true) conv_complete_flag_next = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Bus answer, interrupt and input routing
  // -----------------------------------------------------------------
  always_comb begin
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !mapped;
    prdata_next  = (psel && penable && !pready_reg && !pwrite) ? rdata : 32'h0000_0000;
    irq_next     = conv_complete_flag_next && conv_irq_enable_next;
    pin_sel_next = 4'h0;
    if (channel_select_next <= CH_PIN_LAST)
      pin_sel_next = (4'h1 << channel_select_next[1:0]) & analog_pin_enable_0_next[3:0];
    mux_next = adcs_route(channel_select_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select_reg          <= CH_OFF;
      conv_irq_enable_reg         <= 1'b0;
      continuous_conv_enable_reg  <= 1'b0;
      conv_complete_flag_reg      <= 1'b0;
      hwtrg_sel_reg               <= 1'b0;
      compare_function_enable_reg <= 1'b0;
      cmp_ge_reg                  <= 1'b0;
      cmp_val_reg                 <= '0;
      clk_sel_reg                 <= CLK_BUS;
      mode8_reg                   <= 1'b0;
      long_reg                    <= 1'b0;
      analog_pin_enable_0_reg     <= 8'h00;
      result_reg                  <= '0;
      prdata_reg                  <= 32'h0000_0000;
      pready_reg                  <= 1'b0;
      pslverr_reg                 <= 1'b0;
      div2_reg                    <= 1'b0;
      irq_reg                     <= 1'b0;
      pin_sel_reg                 <= 4'h0;
      mux_reg                     <= 5'h00;
    end else begin
      channel_select_reg          <= channel_select_next;
      conv_irq_enable_reg         <= conv_irq_enable_next;
      continuous_conv_enable_reg  <= continuous_conv_enable_next;
      conv_complete_flag_reg      <= conv_complete_flag_next;
      hwtrg_sel_reg               <= hwtrg_sel_next;
      compare_function_enable_reg <= compare_function_enable_next;
      cmp_ge_reg                  <= cmp_ge_next;
      cmp_val_reg                 <= cmp_val_next;
      clk_sel_reg                 <= clk_sel_next;
      mode8_reg                   <= mode8_next;
      long_reg                    <= long_next;
      analog_pin_enable_0_reg     <= analog_pin_enable_0_next;
      result_reg                  <= result_next;
      prdata_reg                  <= prdata_next;
      pready_reg                  <= pready_next;
      pslverr_reg                 <= pslverr_next;
      div2_reg                    <= div2_next;
      irq_reg                     <= irq_next;
      pin_sel_reg                 <= pin_sel_next;
      mux_reg                     <= mux_next;
    end
  end

  adcs_sar #(
    .BITS (BITS)
  ) u_sar (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (start),
    .abort       (abort),
    .tick        (tick),
    .long_sample (long_reg),
    .comp_in     (comp_in),
    .busy        (busy),
    .sampling    (sampling),
    .done        (done),
    .dac_code    (sar_dac),
    .result      (sar_result)
  );

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign conv_irq    = irq_reg;
  assign dac_code    = sar_dac;
  assign sample_hold = sampling;
  assign mux_pin_sel = pin_sel_reg;
  assign {mux_ground, mux_temp, mux_bandgap, mux_vref_hi, mux_vref_lo} = mux_reg;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  sequence s_write_sc1;
    sc1_wr && pwdata[4:0] != CH_OFF && !hwtrg_sel_reg;
  endsequence

  sequence s_sampling_begins;
    ##1 sampling;
  endsequence

  a_sw_restart: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_sc1 |-> s_sampling_begins) else $error("control write did not start sampling");
  a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    sc1_wr && pwdata[4:0] == CH_OFF |=> !busy && mux_reg == 5'h00 && pin_sel_reg == 4'h0)
    else $error("off code left converter running");
  a_trig_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !hwtrg_sel_reg && !busy && !sc1_wr && !done |=> !busy)
    else $error("idle converter started unasked");
  a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
    trig_ok |=> sampling) else $error("trigger did not start conversion");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (sc1_wr || res_rd) && !done |=> !conv_complete_flag_reg) else $error("flag not cleared");
  a_flag_cmp: assert property (@(posedge pclk) disable iff (!presetn)
    done && compare_function_enable_reg && !cmp_true && !conv_complete_flag_reg
    |=> !conv_complete_flag_reg) else $error("flag set with compare false");
  a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
    done && !compare_function_enable_reg && conv_irq_enable_reg && !sc1_wr
    |=> conv_complete_flag_reg && conv_irq)
    else $error("completion did not raise flag and interrupt");
  a_single_idle: assert property (@(posedge pclk) disable iff (!presetn)
    done && !continuous_conv_enable_reg && !trig_ok && !sc1_wr |=> !busy)
    else $error("single conversion did not return to idle");
  a_alt_no_clk: assert property (@(posedge pclk) disable iff (!presetn)
    clk_sel_reg == CLK_ALT && sampling && !start && !abort |=> sampling)
    else $error("alternate clock advanced conversion");
  a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (mux_pin_sel & ~$past(analog_pin_enable_0_next[3:0])) == 4'h0)
    else $error("disabled pin routed");

endmodule : adcs_top
`default_nettype wire

// *** adcs_afe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcs_afe_model #(
  parameter logic [9:0] TEMP_LVL = 10'h1a5,
  parameter logic [9:0] BG_LVL   = 10'h174
) (
  input  wire logic [3:0][9:0] pin_lvl,
  input  wire logic [3:0]      mux_pin_sel,
  input  wire logic            mux_ground,
  input  wire logic            mux_temp,
  input  wire logic            mux_bandgap,
  input  wire logic            mux_vref_hi,
  input  wire logic            mux_vref_lo,
  input  wire logic [9:0]      dac_code,
  output logic                 comp_in
);
  // An unrouted input floats, so the comparator toggles instead of holding a level.
  always_comb begin
    comp_in = ~dac_code[0];
    for (int i = 0; i < 4; i++) if (mux_pin_sel[i]) comp_in = pin_lvl[i] >= dac_code;
    if (mux_ground || mux_vref_lo) comp_in = dac_code == 10'h000;
    if (mux_temp) comp_in = TEMP_LVL >= dac_code;
    if (mux_bandgap) comp_in = BG_LVL >= dac_code;
    if (mux_vref_hi) comp_in = 1'b1;
  end
endmodule : adcs_afe_model
`default_nettype wire

// *** sar_adc_channel_trigger_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sar_adc_channel_trigger_control_tb
  import adcs_pkg::*;
;
  localparam logic [9:0] TEMP_LVL = 10'h1a5;
  localparam logic [9:0] BG_LVL   = 10'h174;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic hw_conv_trigger = 0, async_conv_clock = 0, mode8 = 0, got, slv;
  logic pready, pslverr, comp_in, sample_hold, conv_irq;
  logic mux_ground, mux_temp, mux_bandgap, mux_vref_hi, mux_vref_lo;
  logic [7:0]      paddr  = 8'h00;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic [1:0]      sys_mode = 2'h0;
  logic [9:0]      dac_code;
  logic [3:0]      mux_pin_sel;
  logic [3:0][9:0] pin_lvl = '0;
  logic [31:0]     cfgs [4] = '{32'h4, 32'h1, 32'h3, 32'h8};
  int errors = 0, checks_done = 0, seed = 32'h2507d8b9;

  always #2 pclk = ~pclk;
  always @(posedge pclk) async_conv_clock <= $random(seed);

  adcs_top u_adcs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hw_conv_trigger, .async_conv_clock, .sys_mode, .comp_in, .dac_code,
    .sample_hold, .mux_pin_sel, .mux_ground, .mux_temp, .mux_bandgap, .mux_vref_hi,
    .mux_vref_lo, .conv_irq);
  adcs_afe_model #(.TEMP_LVL(TEMP_LVL), .BG_LVL(BG_LVL)) u_adcs_afe_model (.pin_lvl,
    .mux_pin_sel, .mux_ground, .mux_temp, .mux_bandgap, .mux_vref_hi, .mux_vref_lo,
    .dac_code, .comp_in);

  // ------
  // Tasks
  // ------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb

  task trig_wait(input logic trig);
    if (trig) begin
      hw_conv_trigger <= 1;
      @(posedge pclk) hw_conv_trigger <= 0;
    end
    got = 0;
    repeat (2) @(posedge pclk);
    for (int n = 0; n < 600 && !got; n++) @(posedge pclk) got = (conv_irq === 1'b1);
  endtask : trig_wait

  task run(input logic [4:0] ch, input logic trig);
    apb(1, ADCS_OFF_SC1, {24'h0, 3'b010, ch});
    trig_wait(trig);
  endtask : run

  function automatic logic [31:0] expv(input logic [4:0] ch);
    logic [9:0] v;
    v = 10'h000;
    if (ch <= CH_PIN_LAST) v = pin_lvl[ch[1:0]];
    if (ch == CH_TEMP) v = TEMP_LVL;
    if (ch == CH_BANDGAP) v = BG_LVL;
    if (ch == 5'h1c || ch == 5'h1d) v = 10'h3ff;
    return mode8 ? {24'h0, v[9:2]} : {22'h0, v};
  endfunction : expv

  task rdres(input logic [4:0] ch);
    apb(0, ADCS_OFF_RESULT, 32'h0);
    chk("result", expv(ch), rd);
  endtask : rdres

  task finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    errors++;
    finish_test;
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ADCS_OFF_SC1, 32'h0);
    chk("sc1 reset", 32'h1f, rd);
    apb(1, ADCS_OFF_PINEN1, 32'hff);
    apb(0, ADCS_OFF_PINEN1, 32'h0);
    chk("pinen1", 32'h0, rd);
    apb(0, 8'h20, 32'h0);
    chk("pslverr", 32'h1, slv);
    apb(1, ADCS_OFF_PINEN0, 32'h0f);
    for (int c = 0; c < 31; c++) begin
      for (int p = 0; p < 4; p++) pin_lvl[p] = $random(seed);
      run(c[4:0], 0);
      chk("done", 32'h1, got);
      if (c < 22 || c > 25) rdres(c[4:0]);
    end
    apb(0, ADCS_OFF_SC1, 32'h0);
    chk("flag clear", 32'h0, rd[SC1_FLAG_BIT]);
    apb(1, ADCS_OFF_PINEN0, 32'h0e);
    apb(1, ADCS_OFF_SC1, 32'h0);
    @(posedge pclk);
    chk("pin gated", 32'h0, mux_pin_sel);
    apb(1, ADCS_OFF_SC1, 32'h1);
    @(posedge pclk);
    chk("pin routed", 32'h2, mux_pin_sel);
    for (int k = 0; k < 4; k++) begin
      apb(1, ADCS_OFF_CFG, cfgs[k]);
      mode8 = cfgs[k][CFG_MODE8_BIT];
      pin_lvl[1] = $random(seed);
      run(5'h01, 0);
      rdres(5'h01);
    end
    apb(1, ADCS_OFF_CFG, 32'h2);
    run(5'h01, 0);
    chk("alt clock", 32'h0, got);
    apb(1, ADCS_OFF_CFG, 32'h9);
    apb(1, ADCS_OFF_SC1, {24'h0, 3'b010, CH_BANDGAP});
    chk("sample_hold", 32'h1, sample_hold);
    chk("mux_bandgap", 32'h1, mux_bandgap);
    trig_wait(0);
    chk("sample_hold idle", 32'h0, sample_hold);
    rdres(CH_BANDGAP);
    apb(1, ADCS_OFF_SC1, {24'h0, 3'b010, CH_TEMP});
    chk("mux_temp", 32'h1, mux_temp);
    trig_wait(0);
    rdres(CH_TEMP);
    apb(1, ADCS_OFF_CFG, 32'h0);
    mode8 = 0;
    run(CH_OFF, 0);
    chk("off", 32'h0, got);
    apb(1, ADCS_OFF_CMPVAL, 32'h100);
    apb(1, ADCS_OFF_SC2, 32'h30);
    run(5'h1e, 0);
    chk("cmp ge false", 32'h0, got);
    run(5'h1c, 0);
    chk("cmp ge true", 32'h1, got);
    apb(1, ADCS_OFF_SC2, 32'h20);
    run(5'h1e, 0);
    chk("cmp lt true", 32'h1, got);
    apb(1, ADCS_OFF_SC2, 32'h40);
    for (int m = 0; m < 4; m++) begin
      sys_mode <= m[1:0];
      run(5'h1c, 1);
      chk("hw trigger", {31'h0, m != 3}, got);
      run(5'h1c, 0);
      chk("hw no trigger", 32'h0, got);
    end
    apb(1, ADCS_OFF_SC2, 32'h0);
    sys_mode <= 2'h0;
    run(5'h1c, 0);
    rdres(5'h1c);
    trig_wait(1);
    chk("trigger ignored", 32'h0, got);
    apb(1, ADCS_OFF_SC1, {24'h0, 3'b011, CH_VREFH_LO});
    trig_wait(0);
    rdres(CH_VREFH_LO);
    trig_wait(0);
    chk("continuous", 32'h1, got);
    apb(1, ADCS_OFF_SC1, {27'h0, CH_OFF});
    apb(0, ADCS_OFF_SC2, 32'h0);
    chk("busy after off", 32'h0, rd[SC2_BUSY_BIT]);
    finish_test;
  end
endmodule : sar_adc_channel_trigger_control_tb
`default_nettype wire
